// ==== tpc_timer_pwm_core.sv ====
// Two-channel timer core with APB registers, prescaler, counter and pin steering.
`default_nettype none
// Overview of operation
// - Two channels, each independently capture, compare or buffered edge PWM.
// - Clock field: 00 stops, 01 bus clock, 10 unused, 11 crystal clock.
// - Crystal-derived 500 kHz clock can drive the timer for oscillator calibration.
// - Crystal clock is synchronised into the bus domain before use.
// - Prescale code 0 to 7 divides by 1 up to 128.
// - Prescaler follows source selection and synchronisation.
// - 16-bit counter: free run, modulo, or up/down for center PWM.
// - Modulo 0x0000 or 0xFFFF gives full 16-bit free running.
// - Counter reads never disturb counting.
// - Any write to either counter byte clears the counter.
// - Up mode: flag sets when counter goes to zero after modulo.
// - Center mode: flag sets stepping down from the modulo value.
// - Flag clears only by read while set, then write zero.
// - New overflow during the clear sequence restarts it; flag stays set.
// - Writing one to the flag does nothing; reset clears it.
// - With interrupt enable set, request interrupt while flag is one.
// - Center select puts all channels into up/down center PWM.
// - Reset leaves timer disabled, bits zero, pins general inputs, no pullups.
// - An owned pin ignores port data and direction, except channel 0 capturing from the oscillator; others return to port.
// - Option bit routes channel 0 from its pin or the oscillator.
// - Capture edges, compare set/clear/toggle, and PWM polarity are selectable.
// - One interrupt per channel plus one overflow interrupt.
module tpc_timer_pwm_core
  import tpc_pkg::*;
(
  input  wire logic          sys_clk_in,
  input  wire logic          rst_b_in,
  input  wire logic          clk_en_in,
  input  wire tpc_apb_req_s  apb_req_in,
  output tpc_apb_rsp_s       apb_rsp_out,
  input  wire logic          crystal_derived_clock_in,
  input  wire logic          low_freq_oscillator_in,
  input  wire logic [1:0]    ch_pin_in,
  output logic      [1:0]    ch_pin_out,
  output logic      [1:0]    ch_pin_oe_out,
  input  wire logic [1:0]    port_data_in,
  input  wire logic [1:0]    port_dir_in,
  output logic      [1:0]    pin_pullup_en_out,
  output logic               overflow_irq_out,
  output logic      [1:0]    channel_irq_out
);
  tpc_core_st_s     q;
  tpc_core_st_s     d;
  logic [7:0]       idx;
  logic             mapped;
  logic             setup;
  logic             acc;
  logic             acc_wr;
  logic             acc_rd;
  logic             cnt_wr;
  logic             center_aligned_pwm;
  logic [1:0]       clks;
  logic [2:0]       ps;
  logic             src_tick;
  logic             tick;
  logic [15:0]      top;
  logic             tof_ev;
  logic [3:0]       raw;
  logic [31:0]      rd_val;
  logic [1:0]       ch_cap;
  logic [1:0]       ch_own;
  logic [1:0]       ch_drive;
  logic [1:0]       ch_out;
  logic [1:0]       ch_irq;
  logic [1:0]       ch_sc_wr;
  logic [1:0]       ch_sc_rd;
  logic [1:0]       ch_v_wr;
  logic [1:0][7:0]  ch_sc;
  logic [1:0][15:0] ch_val;

  // APB decode: one zero-wait access phase, answered from registered data.
  assign idx    = apb_req_in.paddr[9:2];
  assign mapped = apb_req_in.paddr[1:0] == 2'h0 && apb_req_in.paddr[11:10] == 2'h0
                  && idx >= TPC_IDX_SC && idx <= TPC_IDX_SOPT;
  assign setup  = apb_req_in.psel && !apb_req_in.penable && !q.rsp.pready;
  assign acc    = apb_req_in.psel && apb_req_in.penable && q.rsp.pready;
  assign acc_wr = acc && apb_req_in.pwrite && !q.rsp.pslverr;
  assign acc_rd = acc && !apb_req_in.pwrite && !q.rsp.pslverr;
  assign cnt_wr = acc_wr && (idx == TPC_IDX_CNTH || idx == TPC_IDX_CNTL);

  // Control fields.
  assign center_aligned_pwm = q.sc[TPC_SC_CENTER_PWM_SELECT];
  assign clks = q.sc[TPC_SC_CLKS_LSB +: 2];
  assign ps   = q.sc[TPC_SC_PS_LSB +: 3];

  // A modulo of zero counts the full range, the same as all ones.
  assign top = (q.mod == TPC_MOD_RESET) ? TPC_CNT_MAX : q.mod;

  // Pin-side inputs in synchroniser order.
  assign raw = {low_freq_oscillator_in, ch_pin_in, crystal_derived_clock_in};

  // Source selection; the crystal clock counts on its filtered rising edge.
  always_comb begin
    case (clks)
      TPC_CLK_BUS:  src_tick = 1'b1;
      TPC_CLK_XTAL: src_tick = q.sy[TPC_SY_XTAL][1] && q.sy[TPC_SY_XTAL][2] && !q.filt[TPC_SY_XTAL];
      default:      src_tick = 1'b0;
    endcase
  end

  // Prescaler sits after selection, so it divides whichever source runs.
  assign tick = src_tick && q.pre >= tpc_ps_mask(ps) && !cnt_wr;

  // Overflow is held back while only one modulo byte has been written.
  assign tof_ev = tick && q.cnt == top && (!center_aligned_pwm || q.dir == TPC_UP) && !q.mod_pend;

  // Channel 0 listens to the oscillator or its own pin.
  assign ch_cap[0] = q.sopt[TPC_SOPT_ROUTE] ? q.filt[TPC_SY_LFO] : q.filt[1];
  assign ch_cap[1] = q.filt[2];

  // Two identical channels, each with its own register strobes.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign ch_sc_wr[i] = acc_wr && idx == tpc_ch_idx(i, 1'b0);
    assign ch_sc_rd[i] = acc_rd && idx == tpc_ch_idx(i, 1'b0);
    assign ch_v_wr[i]  = acc_wr && idx == tpc_ch_idx(i, 1'b1);

    tpc_channel u_ch (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .clk_en_in  (clk_en_in),
      .cnt_in     (q.cnt),
      .step_in    (q.step_q),
      .tof_in     (q.tof_q),
      .center_aligned_pwm_in    (center_aligned_pwm),
      .cap_in     (ch_cap[i]),
      .sc_wr_in   (ch_sc_wr[i]),
      .sc_rd_in   (ch_sc_rd[i]),
      .v_wr_in    (ch_v_wr[i]),
      .wdata_in   (apb_req_in.pwdata[15:0]),
      .sc_out     (ch_sc[i]),
      .val_out    (ch_val[i]),
      .pin_out    (ch_out[i]),
      .own_out    (ch_own[i]),
      .drive_out  (ch_drive[i]),
      .irq_out    (ch_irq[i])
    );
  end

  // Read mux; the counter bytes come from the latch while a pair is open.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (idx)
      TPC_IDX_SC:   rd_val[7:0] = q.sc;
      TPC_IDX_CNTH: rd_val[7:0] = q.lat_v ? q.cbuf[15:8] : q.cnt[15:8];
      TPC_IDX_CNTL: rd_val[7:0] = q.lat_v ? q.cbuf[7:0] : q.cnt[7:0];
      TPC_IDX_MODH: rd_val[7:0] = q.mod[15:8];
      TPC_IDX_MODL: rd_val[7:0] = q.mod[7:0];
      TPC_IDX_SOPT: rd_val[2:0] = q.sopt;
      default:      rd_val = 32'h0000_0000;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (idx == tpc_ch_idx(i, 1'b0)) begin
        rd_val[7:0] = ch_sc[i];
      end
      if (idx == tpc_ch_idx(i, 1'b1)) begin
        rd_val[15:0] = ch_val[i];
      end
    end
  end

  // Next state of the whole core.
  always_comb begin
    logic taken;
    taken = 1'b0;
    d     = q;

    // Three-stage synchronisers; a level counts once stages two and three agree.
    for (int i = 0; i < 4; i++) begin
      d.sy[i] = {q.sy[i][1:0], raw[i]};
      if (q.sy[i][1] == q.sy[i][2]) begin
        d.filt[i] = q.sy[i][2];
      end
    end

    // Prescaler restarts on a counter write so the first period is whole.
    if (cnt_wr || clks == TPC_CLK_OFF) begin
      d.pre = 7'h00;
    end else if (tick) begin
      d.pre = 7'h00;
    end else if (src_tick) begin
      d.pre = q.pre + 7'h01;
    end

    // Counter: modulo up-count, or up/down when center PWM is selected.
    if (cnt_wr) begin
      d.cnt = TPC_CNT_RESET;
      d.dir = TPC_UP;
    end else if (tick) begin
      if (!center_aligned_pwm) begin
        d.dir = TPC_UP;
        d.cnt = (q.cnt == top) ? TPC_CNT_RESET : q.cnt + 16'h0001;
      end else if (q.dir == TPC_UP) begin
        if (q.cnt >= top) begin
          d.dir = TPC_DOWN;
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else if (q.cnt == TPC_CNT_RESET) begin
        d.dir = TPC_UP;
        d.cnt = 16'h0001;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end

    // Pulses aligned with the new count for the channels.
    d.step_q = tick;
    d.tof_q  = tof_ev;

    // Bus response: ready is raised for exactly the access phase.
    if (setup) begin
      d.rsp.pready  = 1'b1;
      d.rsp.pslverr = !mapped;
      d.rsp.prdata  = apb_req_in.pwrite ? 32'h0000_0000 : rd_val;
      if (!q.lat_v) begin
        d.cbuf = q.cnt;
      end
    end else if (acc) begin
      d.rsp.pready  = 1'b0;
      d.rsp.pslverr = 1'b0;
    end

    // Reading the status while the flag is set arms the clear.
    if (acc_rd && idx == TPC_IDX_SC && q.sc[TPC_SC_TOF]) begin
      d.armed = 1'b1;
    end

    // Reading one counter byte holds the pair until the other byte is read.
    if (acc_rd && (idx == TPC_IDX_CNTH || idx == TPC_IDX_CNTL)) begin
      if (!q.lat_v) begin
        d.lat_v  = 1'b1;
        d.lat_hi = idx == TPC_IDX_CNTH;
      end else if ((idx == TPC_IDX_CNTH) != q.lat_hi) begin
        d.lat_v = 1'b0;
      end
    end

    // Register writes.
    if (acc_wr) begin
      case (idx)
        TPC_IDX_SC: begin
          d.sc[6:0] = apb_req_in.pwdata[6:0];
          d.lat_v   = 1'b0;
          d.armed   = 1'b0;
          if (q.armed && !apb_req_in.pwdata[TPC_SC_TOF]) begin
            d.sc[TPC_SC_TOF] = 1'b0;
          end
        end
        TPC_IDX_CNTH, TPC_IDX_CNTL: begin
          d.lat_v = 1'b0;
        end
        TPC_IDX_MODH, TPC_IDX_MODL: begin
          if (idx == TPC_IDX_MODH) begin
            d.mod[15:8] = apb_req_in.pwdata[7:0];
          end else begin
            d.mod[7:0] = apb_req_in.pwdata[7:0];
          end
          d.mod_pend = !(q.mod_pend && q.mod_hi != (idx == TPC_IDX_MODH));
          d.mod_hi   = idx == TPC_IDX_MODH;
        end
        TPC_IDX_SOPT: begin
          d.sopt = apb_req_in.pwdata[2:0];
        end
        default: begin
          d.sopt = q.sopt;
        end
      endcase
    end

    // A fresh overflow beats a clear in the same cycle and disarms it.
    if (tof_ev) begin
      d.sc[TPC_SC_TOF] = 1'b1;
      d.armed          = 1'b0;
    end

    // The overflow request follows the next flag value; channel requests trail their flags by a cycle.
    d.ovf_irq = d.sc[TPC_SC_TOF] && d.sc[TPC_SC_OVERFLOW_IRQ_ENABLE];
    d.ch_irq  = ch_irq;

    // Pin steering: an owned pin ignores the port settings, except channel 0 capturing from the oscillator.
    for (int i = 0; i < 2; i++) begin
      taken        = ch_own[i] && !(i == 0 && q.sopt[TPC_SOPT_ROUTE] && !ch_drive[i]);
      d.pin_out[i] = (taken && ch_drive[i]) ? ch_out[i] : port_data_in[i];
      d.pin_oe[i]  = taken ? ch_drive[i] : port_dir_in[i];
      d.pull[i]    = taken && !ch_drive[i] && q.sopt[TPC_SOPT_PULL_LSB + i];
    end
  end

  // Whole-core state register; reset leaves the timer off and pins as inputs.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin : p_state
    if (!rst_b_in) begin
      q <= TPC_CORE_RESET;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  // Every output comes from the state register.
  assign apb_rsp_out       = q.rsp;
  assign ch_pin_out        = q.pin_out;
  assign ch_pin_oe_out     = q.pin_oe;
  assign pin_pullup_en_out = q.pull;
  assign overflow_irq_out  = q.ovf_irq;
  assign channel_irq_out   = q.ch_irq;

  // Checks count only enabled clock edges, since state is frozen otherwise.
  default clocking cb_chk @(posedge sys_clk_in iff clk_en_in);
  endclocking
  default disable iff (!rst_b_in);

  chk_cnt_write_clear: assert property (cnt_wr |=> q.cnt == TPC_CNT_RESET && q.dir == TPC_UP)
    else $error("Counter not cleared by a counter write.");

  chk_src_off_stops: assert property (clks == TPC_CLK_OFF && !cnt_wr |=> $stable(q.cnt))
    else $error("Counter moved with the clock source off.");

  chk_bus_div_one: assert property (clks == TPC_CLK_BUS && ps == 3'h0 && !cnt_wr |-> tick)
    else $error("Bus clock at divide one did not step the counter.");

  chk_prescale_two: assert property (tick && clks == TPC_CLK_BUS && ps == 3'h1 |=> !tick)
    else $error("Divide by two stepped on consecutive cycles.");

  chk_prescale_max: assert property (tick && clks == TPC_CLK_BUS && ps == 3'h7 |=> !tick [*8])
    else $error("Divide by 128 stepped too soon.");

  chk_tof_up_wrap: assert property (!center_aligned_pwm && tick && q.cnt == top && !q.mod_pend
                                    |=> q.cnt == TPC_CNT_RESET && q.sc[TPC_SC_TOF])
    else $error("Up-count wrap did not clear counter and set the flag.");

  chk_tof_center: assert property (center_aligned_pwm && tick && q.dir == TPC_UP && q.cnt == top && !q.mod_pend
                                   |=> q.sc[TPC_SC_TOF] && q.dir == TPC_DOWN)
    else $error("Center mode turn at modulo did not set the flag.");

  chk_tof_clear_seq: assert property (q.sc[TPC_SC_TOF] ##1 !q.sc[TPC_SC_TOF]
                                      |-> $past(acc_wr && idx == TPC_IDX_SC && q.armed))
    else $error("Overflow flag cleared without the read-then-write sequence.");

  chk_tof_set_cause: assert property (!q.sc[TPC_SC_TOF] ##1 q.sc[TPC_SC_TOF] |-> $past(tof_ev))
    else $error("Overflow flag set without an overflow.");

  chk_rearm_restart: assert property (q.armed && tof_ev |=> q.sc[TPC_SC_TOF] && !q.armed)
    else $error("Overflow during clear sequence did not restart it.");

  chk_irq_level: assert property (q.ovf_irq == (q.sc[TPC_SC_TOF] && q.sc[TPC_SC_OVERFLOW_IRQ_ENABLE]))
    else $error("Overflow interrupt does not match flag and enable.");

  chk_cnt_read_quiet: assert property (acc_rd && (idx == TPC_IDX_CNTH || idx == TPC_IDX_CNTL) && !tick
                                       |=> $stable(q.cnt))
    else $error("Counter read disturbed the count.");

  chk_gpio_pin_dir: assert property (!ch_own[1] |=> ch_pin_oe_out[1] == $past(port_dir_in[1]))
    else $error("Unowned pin does not follow the port direction.");
endmodule : tpc_timer_pwm_core
`default_nettype wire

// ==== tpc_pkg.sv ====
// Constants, carriers and helper functions shared by the timer core and its channels.
`default_nettype none
package tpc_pkg;
  // Register indices; each register sits at byte address four times its index.
  localparam logic [7:0] TPC_IDX_SC   = 8'h10;
  localparam logic [7:0] TPC_IDX_CNTH = 8'h11;
  localparam logic [7:0] TPC_IDX_CNTL = 8'h12;
  localparam logic [7:0] TPC_IDX_MODH = 8'h13;
  localparam logic [7:0] TPC_IDX_MODL = 8'h14;
  localparam logic [7:0] TPC_IDX_C0SC = 8'h15;
  localparam logic [7:0] TPC_IDX_SOPT = 8'h19;
  localparam int unsigned TPC_CH_STRIDE = 2;
  // Timer status and control fields.
  localparam int unsigned TPC_SC_TOF      = 7;
  localparam int unsigned TPC_SC_OVERFLOW_IRQ_ENABLE     = 6;
  localparam int unsigned TPC_SC_CENTER_PWM_SELECT    = 5;
  localparam int unsigned TPC_SC_CLKS_LSB = 3;
  localparam int unsigned TPC_SC_PS_LSB   = 0;
  localparam logic [1:0]  TPC_CLK_OFF     = 2'h0;
  localparam logic [1:0]  TPC_CLK_BUS     = 2'h1;
  localparam logic [1:0]  TPC_CLK_XTAL    = 2'h3;
  // Channel status and control fields; bits 1 and 0 read as zero.
  localparam int unsigned TPC_CH_FLAG    = 7;
  localparam int unsigned TPC_CH_IE      = 6;
  localparam int unsigned TPC_CH_MS_LSB  = 4;
  localparam int unsigned TPC_CH_ELS_LSB = 2;
  // System option fields: oscillator routing and pullup enables.
  localparam int unsigned TPC_SOPT_ROUTE    = 0;
  localparam int unsigned TPC_SOPT_PULL_LSB = 1;
  // Synchroniser inputs: crystal clock, pin 0, pin 1, low-frequency oscillator.
  localparam int unsigned TPC_SY_XTAL = 0;
  localparam int unsigned TPC_SY_LFO  = 3;
  localparam logic [15:0] TPC_CNT_RESET = 16'h0000;
  localparam logic [15:0] TPC_MOD_RESET = 16'h0000;
  localparam logic [15:0] TPC_CNT_MAX   = 16'hffff;

  typedef enum logic {TPC_UP, TPC_DOWN} tpc_dir_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tpc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tpc_apb_rsp_s;

  typedef struct packed {
    tpc_apb_rsp_s    rsp;
    logic [7:0]      sc;
    logic            armed;
    logic [15:0]     cnt;
    logic [15:0]     mod;
    logic            mod_pend;
    logic            mod_hi;
    tpc_dir_e        dir;
    logic [6:0]      pre;
    logic [15:0]     cbuf;
    logic            lat_v;
    logic            lat_hi;
    logic [2:0]      sopt;
    logic [3:0][2:0] sy;
    logic [3:0]      filt;
    logic            step_q;
    logic            tof_q;
    logic [1:0]      pin_out;
    logic [1:0]      pin_oe;
    logic [1:0]      pull;
    logic            ovf_irq;
    logic [1:0]      ch_irq;
  } tpc_core_st_s;

  typedef struct packed {
    logic [7:0]  sc;
    logic        armed;
    logic [15:0] v;
    logic [15:0] vact;
    logic        out;
    logic        prev;
  } tpc_chan_st_s;

  localparam tpc_core_st_s TPC_CORE_RESET = '0;
  localparam tpc_chan_st_s TPC_CHAN_RESET = '0;

  // Terminal count of the prescaler for a divide code.
  function automatic logic [6:0] tpc_ps_mask(input logic [2:0] ps);
    return 7'((8'h01 << ps) - 8'h01);
  endfunction : tpc_ps_mask

  // Index of a channel's control register (val low) or value register (val high).
  function automatic logic [7:0] tpc_ch_idx(input int unsigned ch, input logic val);
    return TPC_IDX_C0SC + 8'(ch * TPC_CH_STRIDE) + {7'h00, val};
  endfunction : tpc_ch_idx
endpackage : tpc_pkg
`default_nettype wire

// ==== tpc_channel.sv ====
// One timer channel: input capture, output compare, edge and center PWM, flag.
`default_nettype none
module tpc_channel
  import tpc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        clk_en_in,
  input  wire logic [15:0] cnt_in,
  input  wire logic        step_in,
  input  wire logic        tof_in,
  input  wire logic        center_aligned_pwm_in,
  input  wire logic        cap_in,
  input  wire logic        sc_wr_in,
  input  wire logic        sc_rd_in,
  input  wire logic        v_wr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [7:0]  sc_out,
  output logic      [15:0] val_out,
  output logic             pin_out,
  output logic             own_out,
  output logic             drive_out,
  output logic             irq_out
);
  tpc_chan_st_s s;
  tpc_chan_st_s n;
  logic [1:0]   ms;
  logic [1:0]   els;
  logic         cap_m;
  logic         pwm_m;

  assign ms    = s.sc[TPC_CH_MS_LSB +: 2];
  assign els   = s.sc[TPC_CH_ELS_LSB +: 2];
  assign cap_m = !center_aligned_pwm_in && ms == 2'h0;
  assign pwm_m = center_aligned_pwm_in || ms[1];

  // Next state; the compare value is double-buffered in PWM so a period never tears.
  always_comb begin
    logic hit;
    logic edge_ev;
    hit     = step_in && cnt_in == (pwm_m ? s.vact : s.v);
    edge_ev = cap_m && ((els[0] && cap_in && !s.prev) || (els[1] && !cap_in && s.prev));
    n       = s;
    n.prev  = cap_in;
    if (!pwm_m || tof_in) begin
      n.vact = s.v;
    end
    if (v_wr_in) begin
      n.v = wdata_in;
    end
    if (edge_ev) begin
      n.v = cnt_in;
    end
    if (center_aligned_pwm_in) begin
      if (step_in) begin
        n.out = (cnt_in < s.vact) ^ els[0];
      end
    end else if (ms[1]) begin
      if (tof_in) begin
        n.out = !els[0];
      end
      if (hit) begin
        n.out = els[0];
      end
    end else if (ms == 2'h1 && hit) begin
      case (els)
        2'h1:    n.out = !s.out;
        2'h2:    n.out = 1'b0;
        2'h3:    n.out = 1'b1;
        default: n.out = s.out;
      endcase
    end
    // Flag clears only after a read that saw it set; a new event restarts that.
    if (sc_rd_in && s.sc[TPC_CH_FLAG]) begin
      n.armed = 1'b1;
    end
    if (sc_wr_in) begin
      n.sc[6:2] = wdata_in[6:2];
      n.armed   = 1'b0;
      if (s.armed && !wdata_in[TPC_CH_FLAG]) begin
        n.sc[TPC_CH_FLAG] = 1'b0;
      end
    end
    if (edge_ev || (!cap_m && hit)) begin
      n.sc[TPC_CH_FLAG] = 1'b1;
      n.armed           = 1'b0;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin : p_state
    if (!rst_b_in) begin
      s <= TPC_CHAN_RESET;
    end else if (clk_en_in) begin
      s <= n;
    end
  end

  assign sc_out    = s.sc;
  assign val_out   = s.v;
  assign pin_out   = s.out;
  assign own_out   = els != 2'h0;
  assign drive_out = els != 2'h0 && !cap_m;
  assign irq_out   = s.sc[TPC_CH_FLAG] && s.sc[TPC_CH_IE];
endmodule : tpc_channel
`default_nettype wire

// ==== tpc_timer_pwm_core_bench.sv ====
// Self-checking bench for the timer core, driven over its APB port.
`default_nettype none
module timer_pwm_core_bench
  import tpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic err;} tpc_note_s;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         xtal = 1'b0;
  logic [1:0]   pdata = 2'h0;
  logic [1:0]   pdir = 2'h0;
  logic [3:0]   port_q = 4'h0;
  logic         low_freq_oscillator = 1'b0;
  tpc_apb_req_s req = '0;
  tpc_apb_rsp_s rsp;
  logic [1:0]   pin_o, pin_oe, pull, ch_irq;
  logic         ovf_irq;
  int           n_mismatch = 0, checks_done = 0, cyc = 0, seed = 36570;
  tpc_note_s    notes[$];
  logic [15:0]  lo_t[4] = '{16'h0000, 16'h03e8, 16'h0000, 16'h0004};
  logic [15:0]  hi_t[4] = '{16'h0000, 16'h03ec, 16'h0000, 16'h0006};

  tpc_timer_pwm_core dut (
    .sys_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1), .apb_req_in(req), .apb_rsp_out(rsp),
    .crystal_derived_clock_in(xtal), .low_freq_oscillator_in(low_freq_oscillator), .ch_pin_in(2'h0),
    .ch_pin_out(pin_o), .ch_pin_oe_out(pin_oe), .port_data_in(pdata), .port_dir_in(pdir),
    .pin_pullup_en_out(pull), .overflow_irq_out(ovf_irq), .channel_irq_out(ch_irq)
  );

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // The 500 kHz crystal clock is 200 bus cycles; random port settings show which pins ignore them.
  // Free pins follow the port one edge late, so port_q keeps the settings that the pins show now.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 100 == 99) xtal <= ~xtal;
    {pdir, pdata} <= rst_b ? 4'($random(seed)) : 4'h0;
    port_q <= {pdir, pdata};
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got, logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic lvl(string what, logic got, logic exp);
    cmp(what, 32'(exp), 32'(got), got === exp);
  endtask : lvl

  // Read completions are matched in order against the notes left by the driver.
  always @(posedge clk) begin
    tpc_note_s n;
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite && notes.size() > 0) begin
      n = notes.pop_front();
      cmp("read data", n.lo, rsp.prdata, rsp.prdata >= n.lo && rsp.prdata <= n.hi);
      cmp("slave error", 32'(n.err), 32'(rsp.pslverr), rsp.pslverr === n.err);
    end
  end

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(logic [7:0] idx, logic wr, logic [31:0] wd, logic [1:0] lsb);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, {2'b00, idx, lsb}, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    req <= '0;
  endtask : apb

  task automatic wr(logic [7:0] idx, logic [31:0] d);
    apb(idx, 1'b1, d, 2'b00);
  endtask : wr

  task automatic rd(logic [7:0] idx, logic [31:0] lo, logic [31:0] hi, logic err = 1'b0, logic [1:0] lsb = 2'b00);
    notes.push_back('{lo, hi, err});
    apb(idx, 1'b0, 32'h0000_0000, lsb);
  endtask : rd

  // High byte first, so the low byte comes from the same latched count.
  task automatic rd_cnt(logic [15:0] lo, logic [15:0] hi);
    rd(TPC_IDX_CNTH, 32'(lo[15:8]), 32'(hi[15:8]));
    rd(TPC_IDX_CNTL, 32'(lo[7:0]), 32'(hi[7:0]));
  endtask : rd_cnt

  // Main sequence; every count is frozen by stopping the clock before it is read.
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    lvl("pin enable", |pin_oe, 1'b0);
    lvl("pullup", |pull, 1'b0);
    for (int i = 'h10; i <= 'h19; i++) rd(8'(i), 32'h0000_0000, 32'h0000_0000);
    rd(8'h1a, 32'h0000_0000, 32'h0000_0000, 1'b1);
    rd(TPC_IDX_SC, 32'h0000_0000, 32'h0000_0000, 1'b1, 2'b01);
    wr(8'h1a, 32'hffff_ffff);
    $display("test reset_map done");
    for (int p = 0; p < 8; p++) begin
      wr(TPC_IDX_SC, 32'h0000_0008 | 32'(p));
      wr(TPC_IDX_CNTL, 32'h0000_005a);
      repeat (5 << p) @(posedge clk);
      wr(TPC_IDX_SC, 32'(p));
      rd_cnt(16'h0004, 16'h0008);
    end
    $display("test prescale done");
    for (int c = 0; c < 4; c++) begin
      wr(TPC_IDX_SC, 32'(c << 3));
      wr(TPC_IDX_CNTH, 32'h0000_0000);
      repeat (1000) @(posedge clk);
      wr(TPC_IDX_SC, 32'h0000_0000);
      rd_cnt(lo_t[c], hi_t[c]);
    end
    $display("test clock_source done");
    wr(TPC_IDX_MODH, 32'h0000_0000);
    wr(TPC_IDX_MODL, 32'h0000_0003);
    wr(TPC_IDX_SC, 32'h0000_0008);
    wr(TPC_IDX_CNTH, 32'h0000_0000);
    repeat (20) @(posedge clk);
    wr(TPC_IDX_SC, 32'h0000_0080);
    rd_cnt(16'h0000, 16'h0003);
    wr(TPC_IDX_SC, 32'h0000_0040);
    repeat (2) @(posedge clk);
    lvl("overflow irq", ovf_irq, 1'b1);
    rd(TPC_IDX_SC, 32'h0000_00c0, 32'h0000_00c0);
    wr(TPC_IDX_SC, 32'h0000_0040);
    repeat (2) @(posedge clk);
    lvl("overflow irq", ovf_irq, 1'b0);
    wr(TPC_IDX_SC, 32'h0000_00c0);
    rd(TPC_IDX_SC, 32'h0000_0040, 32'h0000_0040);
    $display("test overflow_flag done");
    wr(TPC_IDX_SC, 32'h0000_0028);
    wr(TPC_IDX_CNTH, 32'h0000_0000);
    repeat (20) @(posedge clk);
    wr(TPC_IDX_SC, 32'h0000_00a0);
    rd(TPC_IDX_SC, 32'h0000_00a0, 32'h0000_00a0);
    rd_cnt(16'h0000, 16'h0003);
    wr(TPC_IDX_CNTL, 32'h0000_00a5);
    rd_cnt(16'h0000, 16'h0000);
    $display("test center done");
    wr(TPC_IDX_SC, 32'h0000_0000);
    wr(TPC_IDX_SOPT, 32'h0000_0001);
    wr(TPC_IDX_C0SC, 32'h0000_0044);
    low_freq_oscillator <= 1'b1;
    repeat (8) @(posedge clk);
    lvl("channel 0 irq", ch_irq[0], 1'b1);
    rd(TPC_IDX_C0SC, 32'h0000_00c4, 32'h0000_00c4);
    $display("test capture done");
    wr(TPC_IDX_C0SC, 32'h0000_001c);
    wr(TPC_IDX_SC, 32'h0000_0008);
    repeat (8) @(posedge clk);
    lvl("pin 0 enable", pin_oe[0], 1'b1);
    lvl("pin 0 level", pin_o[0], 1'b1);
    lvl("pin 1 enable", pin_oe[1], port_q[3]);
    lvl("pin 1 level", pin_o[1], port_q[1]);
    lvl("channel 0 irq", ch_irq[0], 1'b0);
    rd(TPC_IDX_SC, 32'h0000_0088, 32'h0000_0088);
    @(posedge clk);
    $display("test pin_owner done");
    tally_and_finish();
  end
endmodule : timer_pwm_core_bench
`default_nettype wire
